//--- verilog/seq_pkg.sv
// Package: address map, codes, timing constants and carrier types of the sequencer
package seq_pkg;
  // ==========================================================
  // Address map (byte addresses, 10-bit space)
  localparam logic [9:0] ADDR_CMD_STATUS = 10'h000;
  localparam logic [9:0] ADDR_RESULT_LO = 10'h010;
  localparam logic [9:0] ADDR_RESULT_HI = 10'h05F;
  localparam logic [9:0] ADDR_GLOBAL_CFG = 10'h0F0;
  localparam logic [9:0] ADDR_MULTI_MASK_LO = 10'h0F4;
  localparam logic [9:0] ADDR_MULTI_MASK_HI = 10'h0F7;
  localparam logic [9:0] ADDR_GLOBAL_STATUS = 10'h0F8;
  localparam logic [9:0] ADDR_MUX_DELAY = 10'h0FF;
  localparam logic [9:0] ADDR_ASSIGN_LO = 10'h200;
  localparam logic [9:0] ADDR_ASSIGN_HI = 10'h24F;
  localparam logic [9:0] ADDR_TABLE_LO = 10'h250;
  localparam logic [9:0] ADDR_TABLE_HI = 10'h3CF;
  localparam int RAM_DEPTH = 1024;
  localparam int NUM_CHANNELS = 20;
  // ==========================================================
  // Serial instruction codes
  localparam logic [7:0] INSTR_READ = 8'h03;
  localparam logic [7:0] INSTR_WRITE = 8'h02;
  // ==========================================================
  // Status byte fields and values
  localparam int STATUS_START_BIT = 7;
  localparam int STATUS_DONE_BIT = 6;
  localparam logic [7:0] STATUS_INIT = 8'h80;
  localparam logic [7:0] STATUS_READY = 8'h40;
  localparam logic [7:0] STATUS_LOCKED = 8'h00;
  localparam logic [7:0] CMD_SLEEP = 8'h97;
  localparam logic [7:0] CMD_CHANNEL_MASK = 8'h1F;
  localparam int SENSOR_TYPE_MSB = 31;
  localparam int SENSOR_TYPE_LSB = 27;
  // ==========================================================
  // Timing
  localparam int SYS_CLK_MHZ = 200;
  localparam int WAKE_MS = 200;
  localparam int PHASE1_MS = 100;
  localparam int WAKE_CYCLES = WAKE_MS * 1000 * SYS_CLK_MHZ;
  localparam int PHASE1_CYCLES = PHASE1_MS * 1000 * SYS_CLK_MHZ;
  localparam int CONV_CYCLES = 1000;
  // ==========================================================
  // Operating states
  typedef enum logic [2:0] {
    ST_STARTUP1 = 3'b000,
    ST_STARTUP2 = 3'b001,
    ST_ASSIGN = 3'b010,
    ST_CONVERT = 3'b011,
    ST_RESULTS = 3'b100,
    ST_SLEEP = 3'b101
  } op_state_t;
  // Completed byte from the link domain
  typedef struct packed {
    logic [7:0] data;
    logic first;
  } link_byte_t;
  // Request to the RAM port
  typedef struct packed {
    logic we;
    logic [9:0] addr;
    logic [7:0] wdata;
  } ram_req_t;
endpackage

//--- verilog/byte_ram.sv
// Byte-wide single-port RAM with registered read data
module byte_ram #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("byte_ram depth exceeds address range");
    end
  end

  // Write then registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- verilog/sensor_ram_spi_sequencer.sv
// Serial RAM access and operating-state sequencer of the temperature digitizer
// Behaviour
// - Read 0x03, address, then data out
// - Write 0x02, address, then data stored
// - Results live at 0x010 to 0x05F
// - Assignment words at 0x200 to 0x24F
// - Write to 0x000 starts conversion
// - Decode config, mask, status, mux delay
// - Custom table 0x250 to 0x3CF in RAM
// - Location 0x000 also takes sleep command
// - Power-up runs 200 ms wake period
// - Start-up done: done pin high, 0x40
// - Enter channel assignment after start-up
// - Command selects channel to convert
// - Convert selected channel and its partner
// - Converting: only status reads allowed
// - Conversion end: done high, start clear
// - Read results state grants full access
// - Supply recovery restarts start-up
// - Reset pin low restarts start-up
// - End of sleep enters start-up
// - Phase one: status inaccessible, 100 ms
// - Then status reads 0x80 only
// - Assignment words reset to zero
// - Top five assignment bits are type
module sensor_ram_spi_sequencer
  import seq_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_CYCLES,
  parameter int PHASE1_COUNT = PHASE1_CYCLES,
  parameter int CONV_COUNT = CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic reset_pin_n,
  input wire logic supply_ok,
  input wire logic sleep_done,
  output logic conv_done,
  output logic [4:0] conv_channel,
  output logic [4:0] conv_partner_channel,
  output logic [4:0] conv_sensor_type,
  output logic conv_active,
  output logic [2:0] op_state,
  output logic [7:0] global_cfg,
  output logic [31:0] multi_mask,
  output logic [7:0] mux_delay,
  input wire logic result_we,
  input wire logic [9:0] result_addr,
  input wire logic [7:0] result_data
);
  import seq_pkg::*;

  initial begin
    // Start-up must last long enough to clear the whole assignment region
    if (WAKE_COUNT <= PHASE1_COUNT || PHASE1_COUNT < 1 || CONV_COUNT < 1
        || WAKE_COUNT <= int'(ADDR_ASSIGN_HI)) begin
      $error("sequencer timing parameters out of range");
    end
  end

  // ==========================================================
  // Link domain: shift register on spi_sck, cs_n is its async reset
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic first_q;
  logic [7:0] rx_byte_q;
  logic rx_first_q;
  logic rx_tog_q;
  logic [7:0] tx_shift_q;

  // Collect one byte per eight rising edges
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      first_q <= 1'b1;
      rx_byte_q <= 8'h00;
      rx_first_q <= 1'b0;
      rx_tog_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= {shift_q[5:0], spi_mosi};
      if (bit_cnt_q == 3'h7) begin
        rx_byte_q <= {shift_q, spi_mosi};
        rx_first_q <= first_q;
        first_q <= 1'b0;
        rx_tog_q <= ~rx_tog_q;
      end
    end
  end

  // Read byte handed over from the system domain, stable for a whole byte
  logic [7:0] tx_hold_q;

  // Shift read data out on falling edges, load at byte boundary
  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      tx_shift_q <= 8'h00;
    end else if (bit_cnt_q == 3'h0) begin
      tx_shift_q <= tx_hold_q;
    end else begin
      tx_shift_q <= {tx_shift_q[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Synchronisers into sys_clk
  logic [2:0] tog_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] rstpin_sync_q;
  logic [1:0] supply_sync_q;
  logic [1:0] sleep_sync_q;
  logic supply_prev_q;
  logic sleep_prev_q;
  logic rstpin_prev_q;

  // Two flops per pin, third stage only for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_sync_q <= 3'h0;
      cs_sync_q <= 2'h3;
      rstpin_sync_q <= 2'h3;
      supply_sync_q <= 2'h3;
      sleep_sync_q <= 2'h0;
      supply_prev_q <= 1'b1;
      sleep_prev_q <= 1'b0;
      rstpin_prev_q <= 1'b1;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], rx_tog_q};
      cs_sync_q <= {cs_sync_q[0], spi_cs_n};
      rstpin_sync_q <= {rstpin_sync_q[0], reset_pin_n};
      supply_sync_q <= {supply_sync_q[0], supply_ok};
      sleep_sync_q <= {sleep_sync_q[0], sleep_done};
      supply_prev_q <= supply_sync_q[1];
      sleep_prev_q <= sleep_sync_q[1];
      rstpin_prev_q <= rstpin_sync_q[1];
    end
  end

  logic byte_evt;
  logic restart_evt;
  assign byte_evt = tog_sync_q[2] ^ tog_sync_q[1];
  // Supply recovery, reset pin falling low, sleep end
  assign restart_evt = (supply_sync_q[1] & ~supply_prev_q)
                     | (~rstpin_sync_q[1] & rstpin_prev_q)
                     | (sleep_sync_q[1] & ~sleep_prev_q);

  // ==========================================================
  // Transaction decoder
  typedef enum logic [2:0] {
    TX_INSTR = 3'b000,
    TX_ADDR_HI = 3'b001,
    TX_ADDR_LO = 3'b010,
    TX_DATA = 3'b011,
    TX_IGNORE = 3'b100
  } txn_state_t;

  txn_state_t txn_q;
  logic is_write_q;
  logic [9:0] addr_q;
  link_byte_t rx_now;
  op_state_t state_q;
  ram_req_t req;
  logic [7:0] ram_rdata;
  logic [7:0] status_q;
  logic [31:0] counter_q;
  logic fire_cmd_q;
  logic [7:0] cmd_byte_q;
  logic rd_pend_q;
  logic rd_load_q;
  logic [9:0] rd_addr_q;

  // Decide if a host access to an address is allowed now
  function automatic logic access_ok(input op_state_t st, input logic [9:0] a,
                                     input logic wr);
    if (st == ST_STARTUP1 || st == ST_SLEEP) begin
      access_ok = 1'b0;
    end else if (st == ST_CONVERT || st == ST_STARTUP2) begin
      access_ok = (a == ADDR_CMD_STATUS) && !wr;
    end else begin
      access_ok = 1'b1;
    end
  endfunction

  // Byte fields captured in the link domain are stable once the toggle is seen
  assign rx_now = '{data: rx_byte_q, first: rx_first_q};

  // Instruction, address and data phases
  always_ff @(posedge sys_clk) begin
    if (rst || cs_sync_q[1]) begin
      txn_q <= TX_INSTR;
      is_write_q <= 1'b0;
      addr_q <= 10'h000;
    end else if (byte_evt) begin
      case (txn_q)
        TX_INSTR: begin
          if (rx_now.data == INSTR_READ) begin
            is_write_q <= 1'b0;
            txn_q <= TX_ADDR_HI;
          end else if (rx_now.data == INSTR_WRITE) begin
            is_write_q <= 1'b1;
            txn_q <= TX_ADDR_HI;
          end else begin
            txn_q <= TX_IGNORE;
          end
        end
        TX_ADDR_HI: begin
          addr_q <= {rx_now.data[1:0], 8'h00};
          txn_q <= TX_ADDR_LO;
        end
        TX_ADDR_LO: begin
          addr_q <= {addr_q[9:8], rx_now.data};
          txn_q <= TX_DATA;
        end
        TX_DATA: begin
          addr_q <= addr_q + 10'h001;
        end
        default: begin
          txn_q <= TX_IGNORE;
        end
      endcase
    end
  end

  // Read prefetch: after the low address byte and after each data byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rd_load_q <= 1'b0;
      rd_addr_q <= 10'h000;
    end else begin
      rd_pend_q <= byte_evt && !is_write_q && !cs_sync_q[1]
                   && (txn_q == TX_ADDR_LO || txn_q == TX_DATA);
      rd_load_q <= rd_pend_q;   // RAM output holds the byte one cycle later
      if (txn_q == TX_ADDR_LO) begin
        rd_addr_q <= {addr_q[9:8], rx_now.data};
      end else begin
        rd_addr_q <= addr_q + 10'h001;
      end
    end
  end

  // ==========================================================
  // RAM port: start-up clearing, else host write, else result write, else read
  always_comb begin
    req = '{we: 1'b0, addr: rd_addr_q, wdata: 8'h00};
    if ((state_q == ST_STARTUP1 || state_q == ST_STARTUP2)
        && counter_q < 32'(RAM_DEPTH)) begin
      req = '{we: 1'b1, addr: counter_q[9:0], wdata: 8'h00};
    end else if (byte_evt && txn_q == TX_DATA && is_write_q && !cs_sync_q[1]
        && access_ok(state_q, addr_q, 1'b1) && addr_q != ADDR_CMD_STATUS) begin
      req = '{we: 1'b1, addr: addr_q, wdata: rx_now.data};
    end else if (result_we && state_q == ST_CONVERT
                 && result_addr >= ADDR_RESULT_LO && result_addr <= ADDR_RESULT_HI) begin
      req = '{we: 1'b1, addr: result_addr, wdata: result_data};
    end
  end

  byte_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(10)
  ) u_ram (
    .clk(sys_clk),
    .we(req.we),
    .addr(req.addr),
    .wdata(req.wdata),
    .rdata(ram_rdata)
  );

  // Read data taken once the registered RAM output holds it; status from the register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_hold_q <= 8'h00;
    end else if (rd_load_q) begin
      if (!access_ok(state_q, addr_q, 1'b0)) begin
        tx_hold_q <= 8'h00;
      end else if (addr_q == ADDR_CMD_STATUS) begin
        tx_hold_q <= status_q;
      end else if (addr_q == ADDR_GLOBAL_STATUS) begin
        tx_hold_q <= {5'h00, state_q};
      end else begin
        tx_hold_q <= ram_rdata;
      end
    end
  end

  // MISO driven while selected, first bit of each byte from tx_hold_q, the rest from the link shift register
  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso <= (bit_cnt_q == 3'h0) ? tx_hold_q[7] : tx_shift_q[6];
      spi_miso_oe <= 1'b1;
    end
  end

  // ==========================================================
  // Command capture from accepted writes to location 0x000 only; reads leave it alone
  logic cmd_wr;
  assign cmd_wr = byte_evt && txn_q == TX_DATA && is_write_q && !cs_sync_q[1]
                  && addr_q == ADDR_CMD_STATUS
                  && (state_q == ST_ASSIGN || state_q == ST_RESULTS);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fire_cmd_q <= 1'b0;
      cmd_byte_q <= 8'h00;
    end else begin
      fire_cmd_q <= cmd_wr;
      if (cmd_wr) begin
        cmd_byte_q <= rx_now.data;
      end
    end
  end

  // Configuration shadows of RAM bytes, kept in step with host writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      global_cfg <= 8'h00;
      multi_mask <= 32'h0000_0000;
      mux_delay <= 8'h00;
    end else if (req.we) begin
      if (req.addr == ADDR_GLOBAL_CFG) begin
        global_cfg <= req.wdata;
      end
      if (req.addr >= ADDR_MULTI_MASK_LO && req.addr <= ADDR_MULTI_MASK_HI) begin
        multi_mask[8*(3-(req.addr[1:0]))+:8] <= req.wdata;
      end
      if (req.addr == ADDR_MUX_DELAY) begin
        mux_delay <= req.wdata;
      end
    end
  end

  // Assignment word of each channel, zero after start-up
  logic [31:0] assign_q [NUM_CHANNELS];
  logic [4:0] widx;
  assign widx = 5'((req.addr - ADDR_ASSIGN_LO) >> 2);

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (rst || state_q == ST_STARTUP1) begin
        assign_q[i] <= 32'h0000_0000;
      end else if (req.we && req.addr >= ADDR_ASSIGN_LO && req.addr <= ADDR_ASSIGN_HI
                   && widx == 5'(i)) begin
        assign_q[i][8*(3-(req.addr[1:0]))+:8] <= req.wdata;
      end
    end
  end

  // ==========================================================
  // Operating state machine with cycle counter
  always_ff @(posedge sys_clk) begin
    if (rst || restart_evt || !supply_sync_q[1]) begin
      state_q <= ST_STARTUP1;
      counter_q <= 32'h0000_0000;
    end else begin
      counter_q <= counter_q + 32'h0000_0001;
      case (state_q)
        ST_STARTUP1: begin
          if (counter_q >= 32'(PHASE1_COUNT - 1)) begin
            state_q <= ST_STARTUP2;
          end
        end
        ST_STARTUP2: begin
          if (counter_q >= 32'(WAKE_COUNT - 1)) begin
            state_q <= ST_ASSIGN;
          end
        end
        ST_ASSIGN, ST_RESULTS: begin
          if (fire_cmd_q) begin
            counter_q <= 32'h0000_0000;
            if (cmd_byte_q == CMD_SLEEP) begin
              state_q <= ST_SLEEP;
            end else if (cmd_byte_q[STATUS_START_BIT]) begin
              state_q <= ST_CONVERT;
            end
          end
        end
        ST_CONVERT: begin
          if (counter_q >= 32'(CONV_COUNT - 1)) begin
            state_q <= ST_RESULTS;
          end
        end
        ST_SLEEP: begin
          state_q <= ST_SLEEP;                      // left only via restart
        end
        default: begin
          state_q <= ST_STARTUP1;
        end
      endcase
    end
  end

  // Status byte, done pin and conversion outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_q <= STATUS_INIT;
      conv_done <= 1'b0;
      conv_channel <= 5'h00;
      conv_partner_channel <= 5'h00;
      conv_sensor_type <= 5'h00;
      conv_active <= 1'b0;
      op_state <= 3'h0;
    end else begin
      op_state <= state_q;
      conv_active <= state_q == ST_CONVERT;
      case (state_q)
        ST_STARTUP1, ST_STARTUP2, ST_SLEEP: begin
          status_q <= STATUS_INIT;
          conv_done <= 1'b0;
        end
        ST_ASSIGN, ST_RESULTS: begin
          status_q <= STATUS_READY;
          conv_done <= 1'b1;
        end
        ST_CONVERT: begin
          status_q <= {1'b1, 1'b0, cmd_byte_q[5:0]};
          conv_done <= 1'b0;
        end
        default: begin
          status_q <= STATUS_INIT;
          conv_done <= 1'b0;
        end
      endcase
      // Sleep code also has the top bit set but selects no channel
      if (fire_cmd_q && cmd_byte_q[STATUS_START_BIT] && cmd_byte_q != CMD_SLEEP) begin
        conv_channel <= cmd_byte_q[4:0] & CMD_CHANNEL_MASK[4:0];
        conv_sensor_type <=
          assign_q[5'(cmd_byte_q[4:0] - 5'h01)][SENSOR_TYPE_MSB:SENSOR_TYPE_LSB];
        conv_partner_channel <= assign_q[5'(cmd_byte_q[4:0] - 5'h01)][26:22];
      end
    end
  end
endmodule

//--- testbench/seq_assertions.sv
// Checker: state sequencing, start-up and conversion timing, serial pin idle level
module seq_checker
  import seq_pkg::*;
#(
  parameter int PHASE1_COUNT = 200,
  parameter int CONV_COUNT = 50
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic reset_pin_n,
  input wire logic supply_ok,
  input wire logic sleep_done,
  input wire logic conv_done,
  input wire logic [4:0] conv_channel,
  input wire logic conv_active,
  input wire logic [2:0] op_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  int unsigned st1_q;
  int unsigned cv_q;
  // ==========================================================
  // Counters
  // Cycles spent in phase one with the supply good
  always_ff @(posedge sys_clk) begin
    if (rst || op_state != ST_STARTUP1 || !supply_ok)
      st1_q <= 0;
    else
      st1_q <= st1_q + 1;
  end
  // Cycles spent converting
  always_ff @(posedge sys_clk) begin
    if (rst || op_state != ST_CONVERT)
      cv_q <= 0;
    else
      cv_q <= cv_q + 1;
  end
  // ==========================================================
  // Properties
  sequence s_ph1_end;
    $past(op_state) == ST_STARTUP1 ##0 op_state == ST_STARTUP2;
  endsequence
  sequence s_conv_end;
    $past(op_state) == ST_CONVERT ##0 op_state == ST_RESULTS;
  endsequence
  property p_ph1_max;
    op_state == ST_STARTUP1 |-> st1_q <= PHASE1_COUNT + 8;
  endproperty
  property p_ph1_len;
    s_ph1_end |-> st1_q >= PHASE1_COUNT - 2;
  endproperty
  property p_assign_done;
    op_state == ST_ASSIGN |-> conv_done;
  endproperty
  property p_conv_end;
    s_conv_end |-> conv_done && !conv_active && cv_q >= CONV_COUNT - 3 && cv_q <= CONV_COUNT + 3;
  endproperty
  property p_conv_lock;
    op_state == ST_CONVERT && $past(op_state) == ST_CONVERT |-> conv_active && !conv_done;
  endproperty
  property p_conv_hold;
    conv_active && $past(conv_active) |-> $stable(conv_channel);
  endproperty
  property p_cs_idle;
    spi_cs_n && $past(spi_cs_n) |-> !spi_miso_oe && !spi_miso;
  endproperty
  property p_supply;
    $fell(supply_ok) |-> ##[1:6] op_state == ST_STARTUP1;
  endproperty
  property p_pin;
    $fell(reset_pin_n) |-> ##[1:6] op_state == ST_STARTUP1;
  endproperty
  property p_wake;
    op_state == ST_SLEEP && $rose(sleep_done) |-> ##[1:6] op_state == ST_STARTUP1;
  endproperty
  a_ph1_max: assert property (p_ph1_max) else $error("phase one too long");
  a_ph1_len: assert property (p_ph1_len) else $error("phase one too short");
  a_assign_done: assert property (p_assign_done) else $error("done low in assign");
  a_conv_end: assert property (p_conv_end) else $error("conversion end wrong");
  a_conv_lock: assert property (p_conv_lock) else $error("convert flags wrong");
  a_conv_hold: assert property (p_conv_hold) else $error("channel moved");
  a_cs_idle: assert property (p_cs_idle) else $error("miso driven unselected");
  a_supply: assert property (p_supply) else $error("no restart on supply");
  a_pin: assert property (p_pin) else $error("no restart on pin");
  a_wake: assert property (p_wake) else $error("no restart after sleep");
endmodule

//--- testbench/spi_host_model.sv
// Host model: serial mode-0 master sending frames byte by byte
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle: clock parked low, device not selected
  initial begin
    {sck, cs_n, mosi, rx_valid, rx_data} = 12'h400;
  end
  // Select the device and give it set-up time
  task automatic begin_frame();
    cs_n = 1'b0;
    #20;
  endtask
  // One byte MSB first; long high time on the last bit lets the reply settle
  task automatic xbyte(input logic [7:0] tx, input logic chk);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #7.5 sck = 1'b1;
      rx[i] = miso;
      #(i == 0 ? 35 : 7.5) sck = 1'b0;
    end
    #20;
    if (chk) begin
      rx_data = rx;
      rx_valid = 1'b1;
      #1 rx_valid = 1'b0;
    end
  endtask
  // Release the device; mosi then carries no stale level
  task automatic end_frame();
    #10 cs_n = 1'b1;
    mosi = ~mosi;
    #40;
  endtask
endmodule

//--- testbench/testbench.sv
// Testbench: start-up, RAM access, conversion, sleep and restart paths
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import seq_pkg::*;
  localparam int PH1 = 400;
  localparam int WAKE = 800;
  localparam int CONV = 1000;
  logic sys_clk, rst, reset_pin_n, supply_ok, sleep_done, result_we, rx_valid;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, conv_done, conv_active;
  logic [4:0] conv_channel, conv_partner_channel, conv_sensor_type;
  logic [2:0] op_state;
  logic [9:0] result_addr;
  logic [7:0] result_data, global_cfg, mux_delay, rx_data, c, rr;
  logic [31:0] multi_mask, w;
  logic [7:0] exp_q[$];
  int seed = 73;
  int fails = 0;
  int total_checks = 0;
  // ==========================================================
  // Clock, design and host
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  sensor_ram_spi_sequencer #(.WAKE_COUNT(WAKE), .PHASE1_COUNT(PH1), .CONV_COUNT(CONV))
  u_sensor_ram_spi_sequencer (.sys_clk(sys_clk), .rst(rst), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .reset_pin_n(reset_pin_n), .supply_ok(supply_ok), .sleep_done(sleep_done),
    .conv_done(conv_done), .conv_channel(conv_channel), .conv_active(conv_active),
    .conv_partner_channel(conv_partner_channel), .conv_sensor_type(conv_sensor_type),
    .op_state(op_state), .global_cfg(global_cfg), .multi_mask(multi_mask),
    .mux_delay(mux_delay), .result_we(result_we), .result_addr(result_addr),
    .result_data(result_data));
  spi_host_model u_host (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso),
    .rx_valid(rx_valid), .rx_data(rx_data));
  // ==========================================================
  // Tasks
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One frame; for reads d holds the expected bytes, noted before they arrive
  task automatic xfer(input logic [7:0] ins, input logic [9:0] a, input logic [7:0] d[$]);
    logic rd;
    rd = (ins == INSTR_READ);
    u_host.begin_frame();
    u_host.xbyte(ins, 1'b0);
    u_host.xbyte({6'h00, a[9:8]}, 1'b0);
    u_host.xbyte(a[7:0], 1'b0);
    foreach (d[i]) begin
      if (rd)
        exp_q.push_back(d[i]);
      u_host.xbyte(rd ? 8'($random(seed)) : d[i], rd);
    end
    u_host.end_frame();
  endtask
  task automatic wait_st(input op_state_t s, input int n);
    for (int i = 0; i < n && op_state !== s; i++)
      @(negedge sys_clk);
    chk(op_state, s);
  endtask
  // Read bytes are matched against the oldest note
  always @(posedge rx_valid) begin
    chk(rx_data, exp_q.pop_front());
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst, reset_pin_n, supply_ok, sleep_done, result_we} = 5'b11100;
    {result_addr, result_data} = 18'h00000;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    xfer(INSTR_READ, ADDR_CMD_STATUS, '{8'h00});
    chk(op_state, ST_STARTUP1);
    wait_st(ST_STARTUP2, PH1);
    xfer(INSTR_READ, ADDR_CMD_STATUS, '{STATUS_INIT});
    wait_st(ST_ASSIGN, WAKE + 50);
    chk(conv_done, 1'b1);
    xfer(INSTR_READ, ADDR_CMD_STATUS, '{STATUS_READY});
    xfer(INSTR_READ, 10'h24C, '{8'h00, 8'h00, 8'h00, 8'h00});
    w = $random(seed);
    c = 8'($random(seed));
    rr = 8'($random(seed));
    xfer(INSTR_WRITE, 10'h208, '{w[31:24], w[23:16], w[15:8], w[7:0]});
    xfer(INSTR_READ, 10'h208, '{w[31:24], w[23:16], w[15:8], w[7:0]});
    xfer(INSTR_WRITE, 10'h3CE, '{c, rr});
    xfer(INSTR_READ, 10'h3CE, '{c, rr});
    xfer(INSTR_WRITE, ADDR_GLOBAL_CFG, '{c});
    xfer(INSTR_WRITE, ADDR_MULTI_MASK_LO, '{w[7:0], w[15:8], w[23:16], w[31:24]});
    xfer(INSTR_WRITE, ADDR_MUX_DELAY, '{rr});
    chk({global_cfg, mux_delay}, {c, rr});
    chk(multi_mask, {w[7:0], w[15:8], w[23:16], w[31:24]});
    xfer(8'h0B, ADDR_GLOBAL_CFG, '{rr});
    chk(global_cfg, c);
    xfer(INSTR_READ, ADDR_GLOBAL_STATUS, '{8'h02});
    xfer(INSTR_WRITE, ADDR_CMD_STATUS, '{8'h83});
    wait_st(ST_CONVERT, 20);
    chk({conv_active, conv_done, conv_channel}, {2'b10, 5'd3});
    chk({conv_sensor_type, conv_partner_channel}, w[31:22]);
    @(negedge sys_clk);
    {result_we, result_addr, result_data} = {1'b1, ADDR_RESULT_LO, rr};
    @(negedge sys_clk);
    result_we = 1'b0;
    xfer(INSTR_READ, ADDR_CMD_STATUS, '{8'h83});
    xfer(INSTR_READ, 10'h208, '{8'h00});
    xfer(INSTR_WRITE, ADDR_GLOBAL_CFG, '{rr});
    chk(global_cfg, c);
    wait_st(ST_RESULTS, CONV);
    chk({conv_active, conv_done}, 2'b01);
    xfer(INSTR_READ, ADDR_CMD_STATUS, '{STATUS_READY});
    xfer(INSTR_READ, ADDR_RESULT_LO, '{rr});
    xfer(INSTR_WRITE, 10'h24F, '{c});
    xfer(INSTR_READ, 10'h24F, '{c});
    xfer(INSTR_WRITE, ADDR_CMD_STATUS, '{CMD_SLEEP});
    wait_st(ST_SLEEP, 20);
    xfer(INSTR_READ, ADDR_GLOBAL_CFG, '{8'h00});
    @(negedge sys_clk);
    sleep_done = 1'b1;
    wait_st(ST_STARTUP1, 10);
    sleep_done = 1'b0;
    wait_st(ST_ASSIGN, WAKE + 50);
    reset_pin_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_pin_n = 1'b1;
    wait_st(ST_STARTUP1, 10);
    wait_st(ST_ASSIGN, WAKE + 50);
    xfer(INSTR_READ, 10'h208, '{8'h00, 8'h00, 8'h00, 8'h00});
    supply_ok = 1'b0;
    wait_st(ST_STARTUP1, 10);
    repeat (20) @(negedge sys_clk);
    chk(op_state, ST_STARTUP1);
    supply_ok = 1'b1;
    wait_st(ST_ASSIGN, WAKE + 50);
    chk(exp_q.size(), 0);
    end_of_test();
  end
endmodule
bind sensor_ram_spi_sequencer seq_checker #(.PHASE1_COUNT(PHASE1_COUNT), .CONV_COUNT(CONV_COUNT))
u_seq_checker (.sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .reset_pin_n(reset_pin_n), .supply_ok(supply_ok),
  .sleep_done(sleep_done), .conv_done(conv_done), .conv_channel(conv_channel),
  .conv_active(conv_active), .op_state(op_state));
